// File: src/global_supervisor_defs.vh
// Constants and register map of the global supervisor block.
// Functional notes
// - Hold logic in reset while supply below power-on threshold; release above it.
// - Undervoltage comparator disabled and its flag ignored in standby.
// - Leaving standby enables undervoltage check; low supply returns to standby.
// - Overvoltage on system supply inhibits operation.
// - Overvoltage comparator disabled while in standby.
// - On-key input debounced for 500us or 30ms by selection.
// - Key mode 0 is push-button, 1 is slide-switch; default from factory option.
// - Debounced on-key falling edge in either mode requests wake-up.
// - Rising on-key edge sets key_rise_int; falling edge sets key_fall_int.
// - On-key manual reset acts only in resource-on state.
// - Push-button: key low for long-press time powers down to standby.
// - Slide-switch: key high for long-press time powers down to standby.
// - Charger insertion wakes only after 120ms debounce.
// - Pull-up select 0 gives strong 200k, 1 gives weak 10M.
// - Always-on domain from charger when detail is 0b11 and not suspended.
// - Open-drain irq_out_n low when any unmasked interrupt bit set.
// - All interrupt masks set after reset; masked bits never drive irq.
// - Power-up releases reset_out_n a delay after last regulator enabled.
// - Power-down asserts reset_out_n a delay before any regulator turns off.
// - Read-only chip_option_id identifies factory option set.
`ifndef GLOBAL_SUPERVISOR_DEFS_VH
`define GLOBAL_SUPERVISOR_DEFS_VH
`define CLK_HZ 40000000
`define DEB_SHORT_US 500
`define DEB_LONG_MS 30
`define CHG_DEB_MS 120
`define LONG_PRESS_A_MS 3300
`define LONG_PRESS_B_MS 8000
`define RST_DELAY_US 100
`define DEB_SHORT_CYC ((`DEB_SHORT_US * (`CLK_HZ / 1000)) / 1000)
`define DEB_LONG_CYC (`DEB_LONG_MS * (`CLK_HZ / 1000))
`define CHG_DEB_CYC (`CHG_DEB_MS * (`CLK_HZ / 1000))
`define LONG_PRESS_A_CYC (`LONG_PRESS_A_MS * (`CLK_HZ / 1000))
`define LONG_PRESS_B_CYC (`LONG_PRESS_B_MS * (`CLK_HZ / 1000))
`define RST_DELAY_CYC ((`RST_DELAY_US * (`CLK_HZ / 1000)) / 1000)
`define ADDR_CONFIG 8'h00
`define ADDR_INT_FLAGS 8'h04
`define ADDR_INT_MASK 8'h08
`define ADDR_STATUS 8'h0C
`define ADDR_CHIP_ID 8'h10
`define CFG_DEB_BIT 0
`define CFG_MODE_BIT 1
`define CFG_LONG_BIT 2
`define CFG_PULLUP_BIT 3
`define CFG_SHUTDOWN_BIT 4
`define INT_FALL_BIT 0
`define INT_RISE_BIT 1
`define INT_CHG_BIT 2
`define INT_UV_BIT 3
`define INT_OV_BIT 4
`define INT_MASK_RESET 5'h1F
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// File: src/global_supervisor.v
// Global supervisor: voltage gating, on-key debounce, power sequencing, interrupt and reset pins.
`timescale 1ns/1ps
`include "global_supervisor_defs.vh"
module global_supervisor #(
   parameter [31:0] deb_short_cyc = `DEB_SHORT_CYC,
   parameter [31:0] deb_long_cyc = `DEB_LONG_CYC,
   parameter [31:0] chg_deb_cyc = `CHG_DEB_CYC,
   parameter [31:0] long_a_cyc = `LONG_PRESS_A_CYC,
   parameter [31:0] long_b_cyc = `LONG_PRESS_B_CYC,
   parameter [31:0] rst_delay_cyc = `RST_DELAY_CYC,
   parameter [4:0] chip_option_id = 5'h0A,
   parameter key_mode_default = 1'b0
) (
   input wire aclk,
   input wire aresetn,
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   input wire supply_por_raw,
   input wire supply_uvlo_flag,
   input wire supply_ovlo_flag,
   input wire on_key_n,
   input wire charger_present,
   input wire [1:0] charger_input_detail,
   input wire usb_suspend,
   input wire last_regulator_on,
   input wire regulators_all_off,
   output reg supply_por_reset,
   output reg uvlo_enable,
   output reg ovlo_enable,
   output reg [1:0] controller_state,
   output reg power_up_req,
   output reg power_down_req,
   output reg key_pullup_weak,
   output reg always_on_from_charger,
   output wire irq_out_n_o,
   output wire irq_out_n_oe,
   output wire reset_out_n_o,
   output wire reset_out_n_oe
);
   localparam [1:0] st_standby = 2'd0;
   localparam [1:0] st_check = 2'd1;
   localparam [1:0] st_on = 2'd2;
   localparam [1:0] st_down = 2'd3;

   ////////////////////////////////////////////////////////////////////////////////
   // Input synchronisers.
   reg [1:0] por_s, uv_s, ov_s, key_s, chg_s, last_s, off_s, usb_s;
   reg [1:0] det_s0, det_s1;
   always @(posedge aclk) begin
      por_s <= {por_s[0], supply_por_raw};
      uv_s <= {uv_s[0], supply_uvlo_flag};
      ov_s <= {ov_s[0], supply_ovlo_flag};
      key_s <= {key_s[0], on_key_n};
      chg_s <= {chg_s[0], charger_present};
      last_s <= {last_s[0], last_regulator_on};
      off_s <= {off_s[0], regulators_all_off};
      usb_s <= {usb_s[0], usb_suspend};
      det_s0 <= charger_input_detail;
      det_s1 <= det_s0;
   end

   // Logic reset combines the bus reset and the supply comparator.
   wire rst = !aresetn || supply_por_reset;
   always @(posedge aclk) begin
      supply_por_reset <= por_s[1];
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Configuration and interrupt registers.
   reg [4:0] settings;
   reg [4:0] int_flags;
   reg [4:0] int_mask;
   wire cfg_deb_long = settings[`CFG_DEB_BIT];
   wire cfg_slide = settings[`CFG_MODE_BIT];
   wire cfg_long_b = settings[`CFG_LONG_BIT];

   ////////////////////////////////////////////////////////////////////////////////
   // On-key debounce and long-press timer.
   reg key_deb;
   reg key_init;
   reg [31:0] deb_cnt;
   reg [31:0] lp_cnt;
   wire [31:0] deb_target = cfg_deb_long ? deb_long_cyc : deb_short_cyc;
   wire [31:0] lp_target = cfg_long_b ? long_b_cyc : long_a_cyc;
   wire key_rise = (key_s[1] != key_deb) && (deb_cnt >= deb_target - 32'd1) && key_s[1];
   wire key_fall = (key_s[1] != key_deb) && (deb_cnt >= deb_target - 32'd1) && !key_s[1];
   // Manual-reset level: low for push-button, high for slide-switch.
   wire mr_level = cfg_slide ? key_deb : !key_deb;
   wire long_press = mr_level && (lp_cnt >= lp_target - 32'd1);

   always @(posedge aclk) begin
      if (rst) begin
         key_deb <= 1'b1;
         key_init <= 1'b0;
         deb_cnt <= 32'd0;
      end else if (!key_init) begin
         key_init <= 1'b1;
         key_deb <= key_s[1];
      end else if (key_s[1] == key_deb) begin
         deb_cnt <= 32'd0;
      end else if (deb_cnt >= deb_target - 32'd1) begin
         key_deb <= key_s[1];
         deb_cnt <= 32'd0;
      end else begin
         deb_cnt <= deb_cnt + 32'd1;
      end
   end

   always @(posedge aclk) begin
      if (rst || !mr_level || key_rise || key_fall || controller_state != st_on) begin
         lp_cnt <= 32'd0;
      end else if (lp_cnt < lp_target - 32'd1) begin
         lp_cnt <= lp_cnt + 32'd1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Charger insertion debounce.
   reg [31:0] chg_cnt;
   reg chg_deb;
   wire chg_wake = chg_s[1] && !chg_deb && (chg_cnt >= chg_deb_cyc - 32'd1);
   always @(posedge aclk) begin
      if (rst) begin
         chg_cnt <= 32'd0;
         chg_deb <= 1'b0;
      end else if (!chg_s[1]) begin
         chg_cnt <= 32'd0;
         chg_deb <= 1'b0;
      end else if (chg_wake) begin
         chg_deb <= 1'b1;
      end else if (!chg_deb) begin
         chg_cnt <= chg_cnt + 32'd1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Power sequence controller with reset output timing.
   reg [31:0] seq_cnt;
   reg rst_out_low;
   reg shutdown_req;
   wire ov_bad = ov_s[1] && ovlo_enable;
   wire uv_bad = uv_s[1] && uvlo_enable;
   always @(posedge aclk) begin
      if (rst) begin
         controller_state <= st_standby;
         seq_cnt <= 32'd0;
         rst_out_low <= 1'b1;
         power_up_req <= 1'b0;
         power_down_req <= 1'b0;
         uvlo_enable <= 1'b0;
         ovlo_enable <= 1'b0;
      end else begin
         case (controller_state)
            st_standby: begin
               uvlo_enable <= 1'b0;
               ovlo_enable <= 1'b0;
               power_up_req <= 1'b0;
               power_down_req <= 1'b0;
               rst_out_low <= 1'b1;
               if (key_fall || chg_wake) begin
                  controller_state <= st_check;
                  uvlo_enable <= 1'b1;
                  ovlo_enable <= 1'b1;
                  seq_cnt <= 32'd0;
               end
            end
            st_check: begin
               // Four cycles let the comparator outputs settle through the synchroniser.
               seq_cnt <= seq_cnt + 32'd1;
               if (seq_cnt >= 32'd3) begin
                  if (uv_bad || ov_bad) begin
                     controller_state <= st_standby;
                  end else begin
                     controller_state <= st_on;
                     power_up_req <= 1'b1;
                     seq_cnt <= 32'd0;
                  end
               end
            end
            st_on: begin
               if (last_s[1] && rst_out_low) begin
                  seq_cnt <= seq_cnt + 32'd1;
                  if (seq_cnt >= rst_delay_cyc - 32'd1) begin
                     rst_out_low <= 1'b0;
                  end
               end
               if (long_press || uv_bad || ov_bad || shutdown_req) begin
                  controller_state <= st_down;
                  rst_out_low <= 1'b1;
                  seq_cnt <= 32'd0;
               end
            end
            st_down: begin
               power_up_req <= 1'b0;
               if (seq_cnt >= rst_delay_cyc - 32'd1) begin
                  power_down_req <= 1'b1;
                  if (off_s[1]) begin
                     controller_state <= st_standby;
                  end
               end else begin
                  seq_cnt <= seq_cnt + 32'd1;
               end
            end
            default: controller_state <= st_standby;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Pins and always-on domain selection.
   wire irq_active = |(int_flags & ~int_mask);
   assign irq_out_n_o = 1'b0;
   assign irq_out_n_oe = !irq_active;
   assign reset_out_n_o = 1'b0;
   assign reset_out_n_oe = !rst_out_low;
   always @(posedge aclk) begin
      always_on_from_charger <= (det_s1 == 2'b11) && !usb_s[1];
      key_pullup_weak <= settings[`CFG_PULLUP_BIT];
   end

   ////////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite slave.
   reg aw_hold, w_hold;
   reg [7:0] aw_addr;
   reg [31:0] w_data;
   reg [3:0] w_strb;
   assign s_axi_awready = !aw_hold && !s_axi_bvalid;
   assign s_axi_wready = !w_hold && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;
   wire wr_go = aw_hold && w_hold;
   wire wr_flags = wr_go && aw_addr == `ADDR_INT_FLAGS && w_strb[0];
   wire [4:0] ev = {ov_bad, uv_bad, chg_wake, key_rise, key_fall};

   always @(posedge aclk) begin
      if (rst) begin
         aw_hold <= 1'b0;
         w_hold <= 1'b0;
         aw_addr <= 8'h00;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `RESP_OKAY;
         settings <= {3'b000, key_mode_default, 1'b0};
         int_mask <= `INT_MASK_RESET;
         shutdown_req <= 1'b0;
      end else begin
         shutdown_req <= 1'b0;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_hold <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_hold <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_hold <= 1'b0;
            w_hold <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= `RESP_OKAY;
            case (aw_addr)
               `ADDR_CONFIG: begin
                  if (w_strb[0]) begin
                     settings <= {1'b0, w_data[3:0]};
                     shutdown_req <= w_data[`CFG_SHUTDOWN_BIT];
                  end
               end
               `ADDR_INT_MASK: begin
                  if (w_strb[0]) begin
                     int_mask <= w_data[4:0];
                  end
               end
               `ADDR_INT_FLAGS, `ADDR_STATUS, `ADDR_CHIP_ID: begin
               end
               default: s_axi_bresp <= `RESP_SLVERR;
            endcase
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Flags are sticky; write one to clear, and a new event wins over the clear.
   genvar i;
   generate
      for (i = 0; i < 5; i = i + 1) begin : g_flag
         always @(posedge aclk) begin
            if (rst) begin
               int_flags[i] <= 1'b0;
            end else if (ev[i]) begin
               int_flags[i] <= 1'b1;
            end else if (wr_flags && w_data[i]) begin
               int_flags[i] <= 1'b0;
            end
         end
      end
   endgenerate

   always @(posedge aclk) begin
      if (rst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= `RESP_OKAY;
         case (s_axi_araddr)
            `ADDR_CONFIG: s_axi_rdata <= {27'd0, settings};
            `ADDR_INT_FLAGS: s_axi_rdata <= {27'd0, int_flags};
            `ADDR_INT_MASK: s_axi_rdata <= {27'd0, int_mask};
            `ADDR_STATUS: s_axi_rdata <= {26'd0, always_on_from_charger, !rst_out_low,
               key_deb, chg_deb, controller_state};
            `ADDR_CHIP_ID: s_axi_rdata <= {27'd0, chip_option_id};
            default: begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= `RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
endmodule // global_supervisor

// File: tb/global_supervisor_monitor.sv
// Port-level checks of the global supervisor, bound to its top module.
`timescale 1ns/1ps
module global_supervisor_monitor #(
   parameter [31:0] rst_delay_cyc = 32'h0000_0003
) (
   input wire aclk,
   input wire aresetn,
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire supply_por_raw,
   input wire supply_ovlo_flag,
   input wire [1:0] charger_input_detail,
   input wire usb_suspend,
   input wire last_regulator_on,
   input wire supply_por_reset,
   input wire uvlo_enable,
   input wire ovlo_enable,
   input wire [1:0] controller_state,
   input wire power_down_req,
   input wire always_on_from_charger,
   input wire irq_out_n_oe,
   input wire reset_out_n_oe
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn || supply_por_reset);
   reg wrote;
   wire aon = charger_input_detail == 2'h3 && !usb_suspend;
   // Remembers whether software has written anything since the last reset.
   always @(posedge aclk) begin
      if (!aresetn || supply_por_reset) wrote <= 1'h0;
      else if (s_axi_bvalid && s_axi_bready) wrote <= 1'h1;
   end
   property p_por_on; disable iff (!aresetn) supply_por_raw [*4] |-> supply_por_reset; endproperty
   a_por_on: assert property (p_por_on) else $error("reset not held at low supply");
   property p_por_off; disable iff (!aresetn) !supply_por_raw [*4] |-> !supply_por_reset; endproperty
   a_por_off: assert property (p_por_off) else $error("reset held at good supply");
   property p_stby; controller_state == 2'h0 ##1 controller_state == 2'h0 |-> !uvlo_enable && !ovlo_enable; endproperty
   a_stby: assert property (p_stby) else $error("comparator enabled in standby");
   property p_chk; controller_state == 2'h1 ##1 controller_state == 2'h1 |-> uvlo_enable && ovlo_enable; endproperty
   a_chk: assert property (p_chk) else $error("comparators off during check");
   property p_ov; (ovlo_enable && supply_ovlo_flag) [*6] |-> controller_state != 2'h2; endproperty
   a_ov: assert property (p_ov) else $error("operation under overvoltage");
   property p_leave; controller_state == 2'h0 |=> controller_state inside {2'h0, 2'h1}; endproperty
   a_leave: assert property (p_leave) else $error("standby left without check");
   property p_mask; !wrote && !s_axi_bvalid |-> irq_out_n_oe; endproperty
   a_mask: assert property (p_mask) else $error("interrupt pin low with reset masks");
   reg [31:0] on_cnt;
   // Counts cycles since the last regulator reported on, saturating.
   always @(posedge aclk) begin
      if (!last_regulator_on) on_cnt <= 32'h0000_0000;
      else if (on_cnt != 32'hFFFF_FFFF) on_cnt <= on_cnt + 32'h0000_0001;
   end
   property p_up;
      $rose(reset_out_n_oe) |-> controller_state == 2'h2 && on_cnt >= rst_delay_cyc;
   endproperty
   a_up: assert property (p_up) else $error("reset released too early");
   property p_dn; controller_state == 2'h3 ##1 controller_state == 2'h3 |-> !reset_out_n_oe; endproperty
   a_dn: assert property (p_dn) else $error("reset not asserted in power-down");
   property p_pdr; $rose(power_down_req) |-> !reset_out_n_oe && $past(reset_out_n_oe, 2) == 1'h0; endproperty
   a_pdr: assert property (p_pdr) else $error("regulators off before reset");
   property p_aon; aon [*4] |-> always_on_from_charger; endproperty
   a_aon: assert property (p_aon) else $error("always-on not from charger");
   property p_bat; !aon [*4] |-> !always_on_from_charger; endproperty
   a_bat: assert property (p_bat) else $error("always-on not from battery");
   c_wake: cover property (controller_state == 2'h1 ##1 controller_state == 2'h2);
   c_down: cover property (controller_state == 2'h3 ##1 controller_state == 2'h0);
   c_irq: cover property (!irq_out_n_oe);
endmodule // global_supervisor_monitor
bind global_supervisor global_supervisor_monitor #(.rst_delay_cyc(rst_delay_cyc)) u_mon (.aclk,
   .aresetn, .s_axi_bvalid, .s_axi_bready, .supply_por_raw, .supply_ovlo_flag,
   .charger_input_detail, .usb_suspend, .last_regulator_on, .supply_por_reset, .uvlo_enable,
   .ovlo_enable, .controller_state, .power_down_req, .always_on_from_charger, .irq_out_n_oe,
   .reset_out_n_oe);

// File: tb/supervisor_far_side.sv
// On-key switch, pulled-up host pins and regulator chain around the supervisor.
`timescale 1ns/1ps
module supervisor_far_side #(
   parameter integer dly = 2
) (
   input wire aclk,
   input wire press,
   input wire power_up_req,
   input wire power_down_req,
   input wire irq_out_n_o,
   input wire irq_out_n_oe,
   input wire reset_out_n_o,
   input wire reset_out_n_oe,
   output wire on_key_n,
   output wire irq_pin,
   output wire rst_pin,
   output reg last_regulator_on = 1'h0,
   output reg regulators_all_off = 1'h1
);
   integer cnt = 0;
   // Regulators come up on the power-up request and stay on until the power-down request.
   wire want = power_down_req ? 1'h0 : (power_up_req || last_regulator_on);
   // Pull-ups hold both host pins high unless the supervisor sinks them.
   assign irq_pin = irq_out_n_oe ? 1'h1 : irq_out_n_o;
   assign rst_pin = reset_out_n_oe ? 1'h1 : reset_out_n_o;
   assign on_key_n = press ? 1'h0 : 1'h1;
   always @(posedge aclk) begin
      if (last_regulator_on == want) begin
         cnt <= 0;
      end else if (cnt < dly) begin
         cnt <= cnt + 1;
      end else begin
         last_regulator_on <= want;
         regulators_all_off <= !want;
         cnt <= 0;
      end
   end
endmodule // supervisor_far_side

// File: tb/global_supervisor_tb.sv
// Self-checking bench for the global supervisor.
`timescale 1ns/1ps
module global_supervisor_tb;
   reg aclk = 1'h0, aresetn = 1'h0, press = 1'h0, usb_suspend = 1'h0, charger_present = 1'h0;
   reg [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   reg [31:0] s_axi_wdata = 32'h0000_0000, rv;
   reg [3:0] s_axi_wstrb = 4'hF;
   reg s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   reg s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   reg supply_por_raw = 1'h0, supply_uvlo_flag = 1'h0, supply_ovlo_flag = 1'h0;
   reg [1:0] charger_input_detail = 2'h0, rr;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire [1:0] s_axi_bresp, s_axi_rresp, controller_state;
   wire [31:0] s_axi_rdata;
   wire supply_por_reset, uvlo_enable, ovlo_enable, power_up_req, power_down_req;
   wire key_pullup_weak, always_on_from_charger, irq_out_n_o, irq_out_n_oe, reset_out_n_o;
   wire reset_out_n_oe, on_key_n, irq_pin, rst_pin, last_regulator_on, regulators_all_off;
   integer fails = 0, total_checks = 0, cyc = 0;
   global_supervisor #(.deb_short_cyc(32'h4), .deb_long_cyc(32'h8), .chg_deb_cyc(32'hA),
      .long_a_cyc(32'h14), .long_b_cyc(32'h1E)) u_dut (.aclk, .aresetn,
      .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .supply_por_raw,
      .supply_uvlo_flag, .supply_ovlo_flag, .on_key_n, .charger_present, .charger_input_detail,
      .usb_suspend, .last_regulator_on, .regulators_all_off, .supply_por_reset, .uvlo_enable,
      .ovlo_enable, .controller_state, .power_up_req, .power_down_req, .key_pullup_weak,
      .always_on_from_charger, .irq_out_n_o, .irq_out_n_oe, .reset_out_n_o, .reset_out_n_oe);
   supervisor_far_side u_far (.aclk, .press, .power_up_req, .power_down_req,
      .irq_out_n_o, .irq_out_n_oe, .reset_out_n_o, .reset_out_n_oe, .on_key_n, .irq_pin,
      .rst_pin, .last_regulator_on, .regulators_all_off);
   initial begin
      forever #12.5 aclk = ~aclk;
   end
   task end_of_test;
      begin
         $display("checks %0d, mismatches %0d", total_checks, fails);
         if (fails == 0 && total_checks > 0) begin
            $display("bench passed");
         end else begin
            $display("bench failed");
         end
         $finish;
      end
   endtask
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         fails = fails + 1;
         end_of_test;
      end
   end
   task chk(input [31:0] got, input [31:0] exp);
      begin
         total_checks = total_checks + 1;
         if (got !== exp) begin
            fails = fails + 1;
            $display("wrong value at %0t ns: got %h, expected %h", $time, got, exp);
         end
      end
   endtask
   task tick(input integer n);
      repeat (n) @(posedge aclk);
   endtask
   task fin(input integer t);
      $display("test %0d finished, %0d mismatches so far", t, fails);
   endtask
   task wr(input [7:0] a, input [31:0] d);
      begin
         s_axi_awaddr <= a;
         s_axi_wdata <= d;
         s_axi_awvalid <= 1'h1;
         s_axi_wvalid <= 1'h1;
         s_axi_bready <= 1'h1;
         do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
         end while (!s_axi_bvalid);
         chk(s_axi_bresp, 2'h0);
      end
   endtask
   task rd(input [7:0] a);
      begin
         s_axi_araddr <= a;
         s_axi_arvalid <= 1'h1;
         s_axi_rready <= 1'h1;
         do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
         end while (!s_axi_rvalid);
         rv = s_axi_rdata;
         rr = s_axi_rresp;
      end
   endtask
   task wst(input [1:0] s);
      integer n;
      begin
         n = 0;
         while (controller_state !== s && n < 5000) begin
            @(posedge aclk);
            n = n + 1;
         end
         chk(controller_state, s);
      end
   endtask
   task push(input integer n);
      begin
         press <= 1'h1;
         tick(n);
         press <= 1'h0;
      end
   endtask
   initial begin
      tick(20);
      aresetn <= 1'h1;
      tick(4);
      rd(8'h10);
      chk(rv, 32'h0000_000A);
      rd(8'h08);
      chk(rv, 32'h0000_001F);
      rd(8'h00);
      chk(rv, 32'h0000_0000);
      rd(8'h14);
      chk(rr, 2'h2);
      chk(rv, 32'h0000_0000);
      fin(1);
      push(12);
      wst(2'h2);
      tick(4030);
      chk(rst_pin, 1'h1);
      rd(8'h0C);
      chk(rv, 32'h0000_001A);
      rd(8'h04);
      chk(rv, 32'h0000_0003);
      chk(irq_pin, 1'h1);
      s_axi_wstrb <= 4'h0;
      wr(8'h08, 32'h0000_0000);
      s_axi_wstrb <= 4'hF;
      tick(2);
      chk(irq_pin, 1'h1);
      wr(8'h08, 32'h0000_001C);
      tick(2);
      chk(irq_pin, 1'h0);
      wr(8'h04, 32'h0000_0003);
      tick(2);
      chk(irq_pin, 1'h1);
      wr(8'h00, 32'h0000_0010);
      wst(2'h3);
      chk(rst_pin, 1'h0);
      wst(2'h0);
      fin(2);
      press <= 1'h1;
      wst(2'h2);
      wst(2'h3);
      press <= 1'h0;
      wst(2'h0);
      push(3);
      tick(20);
      chk(controller_state, 2'h0);
      wr(8'h00, 32'h0000_0001);
      push(7);
      tick(20);
      chk(controller_state, 2'h0);
      fin(3);
      wr(8'h00, 32'h0000_0002);
      press <= 1'h1;
      wst(2'h2);
      tick(40);
      chk(controller_state, 2'h2);
      press <= 1'h0;
      wst(2'h3);
      wst(2'h0);
      wr(8'h00, 32'h0000_0000);
      fin(4);
      push(12);
      wst(2'h2);
      supply_ovlo_flag <= 1'h1;
      wst(2'h3);
      wst(2'h0);
      tick(3);
      chk(ovlo_enable, 1'h0);
      chk(irq_pin, 1'h0);
      supply_ovlo_flag <= 1'h0;
      supply_uvlo_flag <= 1'h1;
      tick(3);
      chk(uvlo_enable, 1'h0);
      push(12);
      tick(40);
      chk(controller_state, 2'h0);
      supply_uvlo_flag <= 1'h0;
      fin(5);
      wr(8'h04, 32'h0000_001F);
      charger_present <= 1'h1;
      charger_input_detail <= 2'h3;
      wst(2'h2);
      chk(always_on_from_charger, 1'h1);
      charger_present <= 1'h0;
      usb_suspend <= 1'h1;
      tick(6);
      chk(always_on_from_charger, 1'h0);
      wr(8'h00, 32'h0000_0018);
      wst(2'h0);
      chk(key_pullup_weak, 1'h1);
      supply_por_raw <= 1'h1;
      tick(5);
      chk(supply_por_reset, 1'h1);
      supply_por_raw <= 1'h0;
      tick(5);
      chk(supply_por_reset, 1'h0);
      chk(key_pullup_weak, 1'h0);
      rd(8'h08);
      chk(rv, 32'h0000_001F);
      fin(6);
      end_of_test;
   end
endmodule // global_supervisor_tb
